// file: cbf_detector.sv
// bus fault detector: level tracking, fault classification, qualification and registers
//
// Function
// RULE1: record after four long-dominant falling transitions
// RULE2: classify faults from wire current comparators
// RULE3: recorded fault sets its own status flag
// RULE4: half termination sets flag bit six
// RULE5: no termination counts as missing termination
// RULE6: wire short bit5, high-battery bit4, low-ground bit3
// RULE7: missing termination or open wire sets bit2
// RULE8: high or both to ground set bit1
// RULE9: low or both to battery set bit0
// RULE10: flags reset zero, sticky, cleared by write
`timescale 1ns/1ps
module cbf_detector
   import cbf_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire logic                  ce,
   input  wire logic                  bus_dominant,
   input  wire logic [CBF_NSENSE-1:0] wire_sense,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [7:0]            reg_rdata,
   output logic                       irq
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // map one sense snapshot to the flag classes it indicates
   function automatic logic [CBF_NFLAG-1:0] classify(input logic [CBF_NSENSE-1:0] s);
      logic [CBF_NFLAG-1:0] f;
      logic                 open_any;
      f        = '0;
      open_any = s[CBF_SNS_LOAD_NONE] | s[CBF_SNS_H_OPEN] | s[CBF_SNS_L_OPEN];
      // RULE2 current based judgement
      f[CBF_BIT_HL]        = s[CBF_SNS_HL];
      // RULE6 separate short flags
      f[CBF_BIT_H_BAT]     = s[CBF_SNS_H_BAT] & ~s[CBF_SNS_L_BAT];
      f[CBF_BIT_L_GND]     = s[CBF_SNS_L_GND] & ~s[CBF_SNS_H_GND];
      // RULE7 opens share one flag
      f[CBF_BIT_OPEN]      = open_any;
      // RULE5 no termination is never half
      // RULE4 half termination flag
      f[CBF_BIT_TERM_HALF] = s[CBF_SNS_LOAD_HALF] & ~open_any;
      // RULE8 high or both to ground
      f[CBF_BIT_GND]       = s[CBF_SNS_H_GND];
      // RULE9 low or both to battery
      f[CBF_BIT_BAT]       = s[CBF_SNS_L_BAT];
      return f;
   endfunction : classify

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction : addr_hit

   // ----------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------
   logic [CBF_SYNC_W-1:0] sync_vec;
   logic                  dom_s;
   logic [CBF_NSENSE-1:0] sense_s;

   cbf_sync #(
      .W        (CBF_SYNC_W)
   ) u_sync (
      .clk      (clk),
      .srst     (srst),
      .ce       (ce),
      .async_in ({bus_dominant, wire_sense}),
      .sync_out (sync_vec)
   );

   assign dom_s   = sync_vec[CBF_SYNC_W-1];
   assign sense_s = sync_vec[CBF_NSENSE-1:0];

   // ----------------------------------------------------------------
   // register file state
   // ----------------------------------------------------------------
   logic [CBF_NFLAG-1:0] flags_q, flags_d;
   logic [CBF_NFLAG-1:0] irq_en_q, irq_en_d;
   logic                 det_en_q, det_en_d;
   logic [7:0]           rdata_q, rdata_d;

   // ----------------------------------------------------------------
   // dominant bit tracker
   // ----------------------------------------------------------------
   cbf_state_t            st_q, st_d;
   logic [CBF_DOM_CW-1:0] dom_cnt_q, dom_cnt_d;
   logic [CBF_NSENSE-1:0] hold_q, hold_d;
   logic                  qual_edge;

   always_comb begin
      st_d      = st_q;
      dom_cnt_d = dom_cnt_q;
      hold_d    = hold_q;
      qual_edge = 1'b0;
      case (st_q)
         CBF_ST_REC: begin
            if (dom_s) begin
               st_d      = CBF_ST_DOM_SHORT;
               dom_cnt_d = {{(CBF_DOM_CW-1){1'b0}}, 1'b1};
               hold_d    = sense_s;
            end
         end
         CBF_ST_DOM_SHORT: begin
            if (!dom_s) begin
               st_d = CBF_ST_REC;
            end else begin
               hold_d    = sense_s;
               dom_cnt_d = dom_cnt_q + {{(CBF_DOM_CW-1){1'b0}}, 1'b1};
               // RULE1 dominant must last the minimum time
               if (dom_cnt_d >= CBF_DOM_MIN) begin
                  st_d = CBF_ST_DOM_LONG;
               end
            end
         end
         CBF_ST_DOM_LONG: begin
            if (!dom_s) begin
               st_d      = CBF_ST_REC;
               qual_edge = 1'b1;
            end else begin
               hold_d = sense_s;
            end
         end
         default: begin
            st_d      = CBF_ST_REC;
            dom_cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q      <= CBF_ST_REC;
         dom_cnt_q <= '0;
         hold_q    <= '0;
      end else if (ce) begin
         st_q      <= st_d;
         dom_cnt_q <= dom_cnt_d;
         hold_q    <= hold_d;
      end
   end

   // ----------------------------------------------------------------
   // fault qualification
   // ----------------------------------------------------------------
   logic [CBF_NFLAG-1:0]   seen;
   logic [CBF_NFLAG-1:0]   fault_set;
   logic [CBF_QUAL_CW-1:0] qcnt_q [CBF_NFLAG];
   logic [CBF_QUAL_CW-1:0] qcnt_d [CBF_NFLAG];

   assign seen = classify(hold_q);

   always_comb begin
      fault_set = '0;
      for (int i = 0; i < CBF_NFLAG; i++) begin
         qcnt_d[i] = qcnt_q[i];
         if (!det_en_q) begin
            qcnt_d[i] = '0;
         end else if (qual_edge) begin
            // RULE1 count successive qualifying transitions
            if (!seen[i]) begin
               qcnt_d[i] = '0;
            end else if (qcnt_q[i] + 3'h1 >= CBF_QUAL_EDGES) begin
               qcnt_d[i]    = '0;
               fault_set[i] = 1'b1;
            end else begin
               qcnt_d[i] = qcnt_q[i] + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int i = 0; i < CBF_NFLAG; i++) begin
         if (srst) begin
            qcnt_q[i] <= '0;
         end else if (ce) begin
            qcnt_q[i] <= qcnt_d[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // register access
   // ----------------------------------------------------------------
   logic [CBF_NFLAG-1:0] clr_mask;
   logic [CBF_QUAL_CW-1:0] max_cnt;

   always_comb begin
      max_cnt = '0;
      for (int i = 0; i < CBF_NFLAG; i++) begin
         if (qcnt_q[i] > max_cnt) begin
            max_cnt = qcnt_q[i];
         end
      end
   end

   always_comb begin
      clr_mask = '0;
      if (reg_wr && (addr_hit(reg_addr, CBF_ADDR_FLAGS) || addr_hit(reg_addr, CBF_ADDR_CLEAR))) begin
         clr_mask = reg_wdata[CBF_NFLAG-1:0];
      end
   end

   always_comb begin
      irq_en_d = irq_en_q;
      det_en_d = det_en_q;
      if (reg_wr && addr_hit(reg_addr, CBF_ADDR_IRQ_EN)) begin
         irq_en_d = reg_wdata[CBF_NFLAG-1:0];
      end
      if (reg_wr && addr_hit(reg_addr, CBF_ADDR_CTRL)) begin
         det_en_d = reg_wdata[CBF_CTRL_EN_BIT];
      end
      // RULE10 sticky until written, new fault beats the clear
      // RULE3 recorded fault sets its own flag
      flags_d = (flags_q & ~clr_mask) | fault_set;
   end

   always_comb begin
      rdata_d = CBF_RDATA_IDLE;
      if (reg_rd) begin
         case (reg_addr)
            // RULE10 reserved top bit reads zero
            CBF_ADDR_FLAGS:  rdata_d = {1'b0, flags_q} & CBF_FLAG_MASK;
            CBF_ADDR_IRQ_EN: rdata_d = {1'b0, irq_en_q};
            CBF_ADDR_CTRL:   rdata_d = {7'h00, det_en_q};
            CBF_ADDR_COUNT:  rdata_d = {3'h0, st_q, max_cnt};
            default:         rdata_d = CBF_RDATA_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         flags_q  <= CBF_FLAGS_RST[CBF_NFLAG-1:0];
         irq_en_q <= CBF_IRQ_EN_RST[CBF_NFLAG-1:0];
         det_en_q <= CBF_CTRL_RST[CBF_CTRL_EN_BIT];
         rdata_q  <= CBF_RDATA_IDLE;
      end else if (ce) begin
         flags_q  <= flags_d;
         irq_en_q <= irq_en_d;
         det_en_q <= det_en_d;
         rdata_q  <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata = rdata_q;
   assign irq       = |(flags_q & irq_en_q);

endmodule : cbf_detector

// file: cbf_pkg.sv
// constants and types shared by the bus fault detector
package cbf_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CBF_ADDR_FLAGS   = 8'h54;
   localparam logic [7:0] CBF_ADDR_CLEAR   = 8'h55;
   localparam logic [7:0] CBF_ADDR_IRQ_EN  = 8'h56;
   localparam logic [7:0] CBF_ADDR_CTRL    = 8'h57;
   localparam logic [7:0] CBF_ADDR_COUNT   = 8'h58;

   localparam logic [7:0] CBF_FLAGS_RST    = 8'h00;
   localparam logic [7:0] CBF_IRQ_EN_RST   = 8'h00;
   localparam logic [7:0] CBF_CTRL_RST     = 8'h01;
   localparam logic [7:0] CBF_RDATA_IDLE   = 8'h00;
   localparam logic [7:0] CBF_FLAG_MASK    = 8'h7F;

   // ----------------------------------------------------------------
   // flag bit positions
   // ----------------------------------------------------------------
   localparam int CBF_NFLAG         = 7;
   localparam int CBF_BIT_BAT       = 0;
   localparam int CBF_BIT_GND       = 1;
   localparam int CBF_BIT_OPEN      = 2;
   localparam int CBF_BIT_L_GND     = 3;
   localparam int CBF_BIT_H_BAT     = 4;
   localparam int CBF_BIT_HL        = 5;
   localparam int CBF_BIT_TERM_HALF = 6;
   localparam int CBF_CTRL_EN_BIT   = 0;

   // ----------------------------------------------------------------
   // current sense comparator inputs
   // ----------------------------------------------------------------
   localparam int CBF_NSENSE        = 9;
   localparam int CBF_SNS_H_BAT     = 0;
   localparam int CBF_SNS_H_GND     = 1;
   localparam int CBF_SNS_L_BAT     = 2;
   localparam int CBF_SNS_L_GND     = 3;
   localparam int CBF_SNS_HL        = 4;
   localparam int CBF_SNS_H_OPEN    = 5;
   localparam int CBF_SNS_L_OPEN    = 6;
   localparam int CBF_SNS_LOAD_HALF = 7;
   localparam int CBF_SNS_LOAD_NONE = 8;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CBF_CLK_PERIOD_NS = 100;
   localparam int CBF_DOM_MIN_NS    = 2000;
   localparam int CBF_DOM_MIN_CYC   = (CBF_DOM_MIN_NS + CBF_CLK_PERIOD_NS - 1) / CBF_CLK_PERIOD_NS;
   localparam int CBF_DOM_CW        = 5;
   localparam logic [CBF_DOM_CW-1:0] CBF_DOM_MIN = CBF_DOM_MIN_CYC[CBF_DOM_CW-1:0];
   localparam int CBF_QUAL_CW       = 3;
   localparam logic [CBF_QUAL_CW-1:0] CBF_QUAL_EDGES = 3'h4;
   localparam int CBF_SYNC_W        = CBF_NSENSE + 1;

   // ----------------------------------------------------------------
   // bus level tracker
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CBF_ST_REC       = 2'b00,
      CBF_ST_DOM_SHORT = 2'b01,
      CBF_ST_DOM_LONG  = 2'b11
   } cbf_state_t;

endpackage : cbf_pkg

// file: cbf_sync.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module cbf_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         ce,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] s1_q, s2_q, s3_q, out_q;
   logic [W-1:0] s1_d, s2_d, s3_d, out_d;

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   always_comb begin
      s1_d  = async_in;
      s2_d  = s1_q;
      s3_d  = s2_q;
      out_d = out_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            out_d[i] = s3_q[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         out_q <= '0;
      end else if (ce) begin
         s1_q  <= s1_d;
         s2_q  <= s2_d;
         s3_q  <= s3_d;
         out_q <= out_d;
      end
   end

   assign sync_out = out_q;

endmodule : cbf_sync

// file: cbf_monitor.sv
// bound checker on the bus fault detector ports
`timescale 1ns/1ps
module cbf_monitor
   import cbf_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  srst,
   input wire logic                  ce,
   input wire logic                  bus_dominant,
   input wire logic [CBF_NSENSE-1:0] wire_sense,
   input wire logic [7:0]            reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  irq
);
   logic [6:0] en_q;
   logic [3:0] low_q;
   // shadow of the interrupt enable and a count of recessive clocks
   always_ff @(posedge clk) begin
      if (srst) begin
         en_q  <= 7'h00;
         low_q <= 4'h0;
      end else begin
         if (ce && reg_wr && reg_addr == CBF_ADDR_IRQ_EN) begin
            en_q <= reg_wdata[6:0];
         end
         low_q <= bus_dominant ? 4'h0 : low_q + {3'h0, low_q != 4'hF};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_top_bit_zero: assert property (reg_rdata[7] == 1'b0)
      else $error("top bit set");
   a_rdata_idle: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("data outside read slot");
   a_freeze_hold: assert property (!ce |=> $stable(reg_rdata) && $stable(irq))
      else $error("moved with enable low");
   a_unmapped_zero: assert property ($past(reg_rd && ce) && $past(reg_addr) > 8'h58 |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_irq_needs_en: assert property (irq |-> en_q != 7'h00)
      else $error("irq with no enable");
   a_mask_off: assert property (ce && reg_wr && reg_addr == CBF_ADDR_IRQ_EN && reg_wdata == 8'h00 |=> !irq)
      else $error("irq not masked");
   a_clear_drops: assert property (ce && reg_wr && reg_addr == CBF_ADDR_CLEAR && reg_wdata == 8'h7F
                                   && low_q >= 4'h8 |=> !irq)
      else $error("irq after clear");
   a_irq_source: assert property ($rose(irq) && !$past(reg_wr) |-> low_q inside {[4'h3:4'h8]})
      else $error("irq not after bus fall");
endmodule : cbf_monitor

bind cbf_detector cbf_monitor cbf_monitor_inst (.clk(clk), .srst(srst), .ce(ce), .bus_dominant(bus_dominant),
   .wire_sense(wire_sense), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .irq(irq));

// file: cbf_bus_model.sv
// bus wiring model: bus level and wire current comparators
`timescale 1ns/1ps
module cbf_bus_model
   import cbf_pkg::*;
(
   input  wire logic                  clk,
   output logic                       bus_dominant,
   output logic      [CBF_NSENSE-1:0] wire_sense
);
   initial begin
      bus_dominant = 1'b0;
      wire_sense   = '0;
   end
   // n frames: dominant for dom clocks, then five recessive, fault currents held through all n frames
   task automatic frames(input int n, input int dom, input logic [CBF_NSENSE-1:0] s);
      repeat (n) begin
         @(posedge clk);
         wire_sense   <= s;
         bus_dominant <= 1'b1;
         repeat (dom) @(posedge clk);
         bus_dominant <= 1'b0;
         repeat (5) @(posedge clk);
      end
      wire_sense <= '0;
   endtask : frames
endmodule : cbf_bus_model

// file: can_bus_fault_detector_tb.sv
// self-checking bench for the bus fault detector
`timescale 1ns/1ps
module can_bus_fault_detector_tb;
   import cbf_pkg::*;
   logic                  clk, srst, ce, reg_wr, reg_rd, irq, bus_dominant;
   logic [CBF_NSENSE-1:0] wire_sense;
   logic [7:0]            reg_addr, reg_wdata, reg_rdata;
   int                    errors, tests_run, cyc;
   logic [CBF_NSENSE-1:0] sns [12] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020,
                                       9'h040, 9'h080, 9'h100, 9'h00A, 9'h005, 9'h180};
   logic [7:0]            flg [12] = '{8'h10, 8'h02, 8'h01, 8'h08, 8'h20, 8'h04,
                                       8'h04, 8'h40, 8'h04, 8'h02, 8'h01, 8'h04};

   cbf_detector cbf_detector_inst (.clk(clk), .srst(srst), .ce(ce), .bus_dominant(bus_dominant),
      .wire_sense(wire_sense), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   cbf_bus_model cbf_bus_model_inst (.clk(clk), .bus_dominant(bus_dominant), .wire_sense(wire_sense));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rd
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end

   initial begin
      srst      = 1'b1;
      ce        = 1'b1;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(CBF_ADDR_FLAGS, 8'h00);
      rd(CBF_ADDR_IRQ_EN, 8'h00);
      rd(CBF_ADDR_CTRL, 8'h01);
      wr(CBF_ADDR_COUNT, 8'hFF);
      rd(CBF_ADDR_COUNT, 8'h00);
      rd(8'h60, 8'h00);
      $display("test reset and map done");
      wr(CBF_ADDR_IRQ_EN, 8'h7F);
      for (int i = 0; i < 12; i++) begin
         cbf_bus_model_inst.frames(3, 25, sns[i]);
         rd(CBF_ADDR_FLAGS, 8'h00);
         cbf_bus_model_inst.frames(1, 25, sns[i]);
         repeat (3) @(posedge clk);
         rd(CBF_ADDR_FLAGS, flg[i]);
         chk({7'h00, irq}, 8'h01);
         cbf_bus_model_inst.frames(1, 25, '0);
         rd(CBF_ADDR_FLAGS, flg[i]);
         wr(CBF_ADDR_CLEAR, 8'h7F);
         rd(CBF_ADDR_FLAGS, 8'h00);
      end
      $display("test fault classes done");
      cbf_bus_model_inst.frames(3, 25, sns[4]);
      cbf_bus_model_inst.frames(4, 12, sns[4]);
      rd(CBF_ADDR_FLAGS, 8'h00);
      rd(CBF_ADDR_COUNT, 8'h03);
      cbf_bus_model_inst.frames(1, 25, sns[4]);
      repeat (3) @(posedge clk);
      rd(CBF_ADDR_FLAGS, 8'h20);
      wr(CBF_ADDR_IRQ_EN, 8'h00);
      #1 chk({7'h00, irq}, 8'h00);
      wr(CBF_ADDR_IRQ_EN, 8'h20);
      #1 chk({7'h00, irq}, 8'h01);
      wr(CBF_ADDR_FLAGS, 8'h20);
      #1 chk({7'h00, irq}, 8'h00);
      rd(CBF_ADDR_FLAGS, 8'h00);
      $display("test short dominant and irq done");
      wr(CBF_ADDR_CTRL, 8'h00);
      cbf_bus_model_inst.frames(4, 25, sns[4]);
      rd(CBF_ADDR_FLAGS, 8'h00);
      rd(CBF_ADDR_COUNT, 8'h00);
      wr(CBF_ADDR_CTRL, 8'h01);
      @(posedge clk);
      ce <= 1'b0;
      wr(CBF_ADDR_IRQ_EN, 8'h7F);
      rd(CBF_ADDR_CTRL, 8'h00);
      @(posedge clk);
      ce <= 1'b1;
      rd(CBF_ADDR_IRQ_EN, 8'h20);
      cbf_bus_model_inst.frames(4, 25, sns[4]);
      #1 chk({7'h00, irq}, 8'h01);
      @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      #1 chk({7'h00, irq}, 8'h00);
      rd(CBF_ADDR_FLAGS, 8'h00);
      rd(CBF_ADDR_IRQ_EN, 8'h00);
      rd(CBF_ADDR_CTRL, 8'h01);
      $display("test enable, freeze and reset done");
      print_verdict();
   end
endmodule : can_bus_fault_detector_tb
